// File: logic/oscsel_pkg.sv
// Purpose: shared constants of the oscillator select and switch control
// Assumes: 32-bit classic Wishbone, registers on aligned words
// Notes: source codes are shared by the current and new source fields

package oscsel_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
    localparam logic [7:0] OFS_DIV_CTRL = 8'h04;
    localparam logic [7:0] OFS_UNLOCK = 8'h08;

    // oscillator control/status field positions
    localparam int CUR_SRC_LSB = 12;
    localparam int NEW_SRC_LSB = 8;
    localparam int SEL_LOCK_BIT = 7;
    localparam int PIN_LOCK_BIT = 6;
    localparam int PLL_LOCK_BIT = 5;
    localparam int FAIL_BIT = 3;
    localparam int PRI_SLEEP_BIT = 2;
    localparam int SEC_EN_BIT = 1;
    localparam int SW_REQ_BIT = 0;

    // divider control field positions
    localparam int DIV_SRC_LSB = 8;
    localparam int POST_LSB = 6;
    localparam int PLL_ON_BIT = 5;

    // source codes
    localparam logic [2:0] SRC_FAST_RC = 3'h0;
    localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRIMARY = 3'h2;
    localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
    localparam logic [2:0] SRC_SECONDARY = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
    localparam logic [2:0] SRC_RESERVED = 3'h6;
    localparam logic [2:0] SRC_DIVIDED = 3'h7;

    // primary submode codes
    localparam logic [1:0] PRI_EXT_CLOCK = 2'h0;
    localparam logic [1:0] PRI_CRYSTAL = 2'h1;
    localparam logic [1:0] PRI_HS_CRYSTAL = 2'h2;
    localparam logic [1:0] PRI_OFF = 2'h3;

    // reset values (erased configuration)
    localparam logic [2:0] RST_SOURCE = 3'h7;
    localparam logic [2:0] RST_DIV_SRC = 3'h0;
    localparam logic [1:0] RST_MONITOR_CFG = 2'h3;
    localparam logic [1:0] RST_SUBMODE_CFG = 2'h3;

    // unlock keys, written in order to the unlock register
    localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h57;

    // timing
    localparam int CLK_MHZ = 125;
    localparam int PLL_START_NS = 2000;
    localparam int PLL_START_CYC = (PLL_START_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_NS = 32;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CFG_SYNC_CYC = 2;

endpackage : oscsel_pkg

// File: logic/oscsel_switch_seq.sv
// Purpose: break-before-make sequencer for a clock source change
// Assumes: start_i is a single-cycle pulse given only while idle
// Notes: every gate stays off for the settle time before the new one opens

`timescale 1ns/1ps
`default_nettype none

module oscsel_switch_seq (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // control
    input wire logic start_i,
    // status
    output logic busy_o,
    output logic gate_off_o,
    output logic done_o
);

    typedef enum logic [0:0] {
        SEQ_IDLE,
        SEQ_OFF
    } oscsel_seq_state_t;

    localparam logic [3:0] LAST_CNT = 4'(oscsel_pkg::SETTLE_CYC - 1);

    oscsel_seq_state_t state_q;
    logic [3:0] cnt_q;

    // state walk: idle, then all gates closed for the settle window
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= SEQ_IDLE;
        end else begin
            unique case (state_q)
                SEQ_IDLE: begin
                    if (start_i) begin
                        state_q <= SEQ_OFF;
                    end
                end
                SEQ_OFF: begin
                    if (cnt_q == LAST_CNT) begin
                        state_q <= SEQ_IDLE;
                    end
                end
            endcase
        end
    end

    // settle counter
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 4'h0;
        end else if (state_q == SEQ_OFF) begin
            cnt_q <= cnt_q + 4'h1;
        end else begin
            cnt_q <= 4'h0;
        end
    end

    // status outputs
    assign busy_o = (state_q == SEQ_OFF);
    assign gate_off_o = (state_q == SEQ_OFF);
    assign done_o = (state_q == SEQ_OFF) && (cnt_q == LAST_CNT);

    AST_SEQ_BREAK: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (start_i && !busy_o) |=> (gate_off_o && !done_o)[*3]
        ##1 (gate_off_o && done_o) ##1 !busy_o)
        else $error("switch sequence length wrong");

endmodule : oscsel_switch_seq

`default_nettype wire

// File: logic/oscsel_top.sv
// Purpose: clock source select, switch and lock control with Wishbone regs
// Assumes: configuration and oscillator status pins are asynchronous
// Notes: oscillator control register writes need the two-key unlock just before; divider control writes need none
//
// How it works
// - switch requests act only when switch/monitor config upper bit is 0
// - fail-safe monitor runs only when switch/monitor config equals 00
// - startup source config picks the clock source after power-on
// - primary submode drives primary oscillator; 11 for non-primary sources
// - divided mode input comes from divider source select, fast RC at reset
// - erased configuration starts divided mode fed by fast RC
// - pin function config picks output or I/O for internal sources
// - control register writes ignored unless unlock keys written just before; divider control writes here take effect without the keys
// - current source field bits 14-12 shows source in use
// - software writes requested source into new source bits 10-8
// - both source fields load from startup config after reset
// - with monitor on, selection lock bit 7 freezes clock selections
// - with monitor off, selections are never locked
// - lock ignores new source, request, postscaler and PLL-on writes
// - pin lock bit 6 changes only after the unlock sequence
// - one-way config keeps pin lock set until reset
// - PLL lock reads 0 at reset, during switch, in non-PLL modes
// - clock-fail flag clears by writing 0; writing 1 does nothing
// - PLL lock reads 1 when locked or startup timer expired
// - monitor-detected failure sets the clock-fail flag
// - request bit 0 starts switch; hardware clears it when complete
// - sleep enable and secondary enable drive the oscillators
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.

`timescale 1ns/1ps
`default_nettype none

module oscsel_top (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // nonvolatile configuration
    input wire logic [1:0] switch_monitor_cfg_i,
    input wire logic [1:0] primary_submode_cfg_i,
    input wire logic [2:0] startup_source_cfg_i,
    input wire logic osc_out_pin_function_cfg_i,
    input wire logic one_way_pin_lock_cfg_i,
    // oscillator status
    input wire logic pll_in_lock_i,
    input wire logic clock_fail_detect_i,
    // clock tree controls
    output logic [7:0] clock_gate_en_o,
    output logic [2:0] current_source_o,
    output logic [1:0] primary_submode_o,
    output logic primary_output_pin_gpio_o,
    output logic [2:0] divider_source_select_o,
    output logic pll_enable_o,
    output logic [1:0] pll_postscaler_select_o,
    output logic fail_safe_monitor_en_o,
    output logic pin_config_lock_o,
    output logic primary_sleep_enable_o,
    output logic secondary_enable_o
);

    // two-flop synchronisers for the pins
    logic [10:0] pin_meta_q;
    logic [10:0] pin_sync_q;
    logic [1:0] mon_cfg;
    logic [1:0] sub_cfg;
    logic [2:0] start_cfg;
    logic pin_fn_cfg;
    logic one_way_cfg;
    logic pll_lock_s;
    logic fail_s;

    // init and bus
    logic [1:0] init_cnt_q;
    logic loaded_q;
    logic load;
    logic ack_q;
    logic [31:0] dat_q;
    logic req;
    logic wr_req;
    logic key_stage_q;
    logic unlocked_q;
    logic osc_wr;
    logic div_wr;

    // control state
    logic [2:0] cur_src_q;
    logic [2:0] new_src_q;
    logic sel_lock_q;
    logic pin_lock_q;
    logic pll_lock_q;
    logic fail_q;
    logic pri_sleep_q;
    logic sec_en_q;
    logic sw_req_q;
    logic [2:0] div_src_q;
    logic [1:0] post_q;
    logic pll_on_q;
    logic [7:0] pll_tmr_q;

    // derived
    logic switch_allowed;
    logic monitor_en;
    logic lock_eff;
    logic pll_mode;
    logic primary_mode;
    logic seq_start;
    logic seq_busy;
    logic seq_gate_off;
    logic seq_done;
    logic [15:0] osc_rd;
    logic [15:0] div_rd;

    localparam logic [7:0] PLL_LAST = 8'(oscsel_pkg::PLL_START_CYC - 1);
    localparam logic [1:0] INIT_LAST = 2'(oscsel_pkg::CFG_SYNC_CYC);
    // upper ends of the multi-bit write fields
    localparam int NEW_HI = oscsel_pkg::NEW_SRC_LSB + 2;
    localparam int DIV_HI = oscsel_pkg::DIV_SRC_LSB + 2;
    localparam int POST_HI = oscsel_pkg::POST_LSB + 1;

    // pin synchronisers; reset to the erased configuration
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_meta_q <= {2'h0, 1'b1, 1'b1, oscsel_pkg::RST_SOURCE,
                           oscsel_pkg::RST_SUBMODE_CFG,
                           oscsel_pkg::RST_MONITOR_CFG};
            pin_sync_q <= {2'h0, 1'b1, 1'b1, oscsel_pkg::RST_SOURCE,
                           oscsel_pkg::RST_SUBMODE_CFG,
                           oscsel_pkg::RST_MONITOR_CFG};
        end else begin
            pin_meta_q <= {clock_fail_detect_i, pll_in_lock_i,
                           one_way_pin_lock_cfg_i, osc_out_pin_function_cfg_i,
                           startup_source_cfg_i, primary_submode_cfg_i,
                           switch_monitor_cfg_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign mon_cfg = pin_sync_q[1:0];
    assign sub_cfg = pin_sync_q[3:2];
    assign start_cfg = pin_sync_q[6:4];
    assign pin_fn_cfg = pin_sync_q[7];
    assign one_way_cfg = pin_sync_q[8];
    assign pll_lock_s = pin_sync_q[9];
    assign fail_s = pin_sync_q[10];

    assign switch_allowed = !mon_cfg[1];
    assign monitor_en = (mon_cfg == 2'h0);
    assign lock_eff = sel_lock_q && monitor_en;
    assign pll_mode = (cur_src_q == oscsel_pkg::SRC_PRIMARY_PLL) ||
                      (cur_src_q == oscsel_pkg::SRC_FAST_RC_PLL);
    assign primary_mode = (cur_src_q == oscsel_pkg::SRC_PRIMARY_PLL) ||
                          (cur_src_q == oscsel_pkg::SRC_PRIMARY);

    // config capture waits until the synchronisers hold real pin values
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            init_cnt_q <= 2'h0;
            loaded_q <= 1'b0;
        end else if (!loaded_q) begin
            init_cnt_q <= init_cnt_q + 2'h1;
            loaded_q <= (init_cnt_q == INIT_LAST);
        end
    end
    assign load = !loaded_q && (init_cnt_q == INIT_LAST);

    // bus: ack one cycle after the request, writes act on the ack edge
    assign req = wb_cyc_i && wb_stb_i && loaded_q;
    assign wr_req = req && wb_we_i && ack_q;
    assign osc_wr = wr_req && (wb_adr_i == oscsel_pkg::OFS_OSC_CTRL) &&
                    unlocked_q;
    assign div_wr = wr_req && (wb_adr_i == oscsel_pkg::OFS_DIV_CTRL);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    // read data captured with the request, unmapped reads give zero
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dat_q <= 32'h0;
        end else if (req && !ack_q) begin
            unique case (wb_adr_i)
                oscsel_pkg::OFS_OSC_CTRL: dat_q <= {16'h0, osc_rd};
                oscsel_pkg::OFS_DIV_CTRL: dat_q <= {16'h0, div_rd};
                default: dat_q <= 32'h0;
            endcase
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // unlock keys; any other write closes the window again
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            key_stage_q <= 1'b0;
            unlocked_q <= 1'b0;
        end else if (wr_req) begin
            if (wb_adr_i == oscsel_pkg::OFS_UNLOCK && wb_sel_i[0]) begin
                key_stage_q <= (wb_dat_i[7:0] == oscsel_pkg::UNLOCK_KEY1);
                unlocked_q <= key_stage_q &&
                              (wb_dat_i[7:0] == oscsel_pkg::UNLOCK_KEY2);
            end else begin
                key_stage_q <= 1'b0;
                unlocked_q <= 1'b0;
            end
        end
    end

    // current source loads from config, then follows switches
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cur_src_q <= oscsel_pkg::RST_SOURCE;
        end else if (load) begin
            cur_src_q <= start_cfg;
        end else if (seq_done) begin
            cur_src_q <= new_src_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            new_src_q <= oscsel_pkg::RST_SOURCE;
        end else if (load) begin
            new_src_q <= start_cfg;
        end else if (osc_wr && wb_sel_i[1] && !lock_eff && !sw_req_q) begin
            new_src_q <= wb_dat_i[NEW_HI:oscsel_pkg::NEW_SRC_LSB];
        end
    end
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_lock_q <= 1'b0;
        end else if (osc_wr && wb_sel_i[0]) begin
            sel_lock_q <= wb_dat_i[oscsel_pkg::SEL_LOCK_BIT];
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_lock_q <= 1'b0;
        end else if (osc_wr && wb_sel_i[0] &&
                     !(one_way_cfg && pin_lock_q)) begin
            pin_lock_q <= wb_dat_i[oscsel_pkg::PIN_LOCK_BIT];
        end
    end

    // clock-fail flag; a failure wins over a clear
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fail_q <= 1'b0;
        end else if (fail_s && monitor_en) begin
            fail_q <= 1'b1;
        end else if (osc_wr && wb_sel_i[0] &&
                     !wb_dat_i[oscsel_pkg::FAIL_BIT]) begin
            fail_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pri_sleep_q <= 1'b0;
            sec_en_q <= 1'b0;
        end else if (osc_wr && wb_sel_i[0]) begin
            pri_sleep_q <= wb_dat_i[oscsel_pkg::PRI_SLEEP_BIT];
            sec_en_q <= wb_dat_i[oscsel_pkg::SEC_EN_BIT];
        end
    end

    // switch request; hardware only clears it
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sw_req_q <= 1'b0;
        end else if (seq_done) begin
            sw_req_q <= 1'b0;
        end else if (sw_req_q && !seq_busy &&
                     new_src_q == oscsel_pkg::SRC_RESERVED) begin
            sw_req_q <= 1'b0;
        end else if (osc_wr && wb_sel_i[0] && !lock_eff && switch_allowed &&
                     wb_dat_i[oscsel_pkg::SW_REQ_BIT]) begin
            sw_req_q <= 1'b1;
        end
    end

    // reserved code never starts the sequencer
    assign seq_start = sw_req_q && !seq_busy &&
                       (new_src_q != oscsel_pkg::SRC_RESERVED);

    oscsel_switch_seq u_seq (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .start_i(seq_start),
        .busy_o(seq_busy),
        .gate_off_o(seq_gate_off),
        .done_o(seq_done)
    );

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_src_q <= oscsel_pkg::RST_DIV_SRC;
            post_q <= 2'h0;
            pll_on_q <= 1'b0;
        end else if (div_wr) begin
            if (wb_sel_i[1]) begin
                div_src_q <= wb_dat_i[DIV_HI:oscsel_pkg::DIV_SRC_LSB];
            end
            if (wb_sel_i[0] && !lock_eff) begin
                post_q <= wb_dat_i[POST_HI:oscsel_pkg::POST_LSB];
                pll_on_q <= wb_dat_i[oscsel_pkg::PLL_ON_BIT];
            end
        end
    end

    // PLL start-up timer restarts on every switch or non-PLL mode
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pll_tmr_q <= 8'h0;
        end else if (seq_busy || !pll_mode) begin
            pll_tmr_q <= 8'h0;
        end else if (pll_tmr_q != PLL_LAST) begin
            pll_tmr_q <= pll_tmr_q + 8'h1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pll_lock_q <= 1'b0;
        end else begin
            pll_lock_q <= pll_mode && !seq_busy &&
                          (pll_lock_s || pll_tmr_q == PLL_LAST);
        end
    end

    // read images, unimplemented bits tied low
    assign osc_rd = {1'b0, cur_src_q, 1'b0, new_src_q, sel_lock_q,
                     pin_lock_q, pll_lock_q, 1'b0, fail_q, pri_sleep_q,
                     sec_en_q, sw_req_q};
    assign div_rd = {5'h0, div_src_q, post_q, pll_on_q, 5'h0};

    // clock tree: every gate closed while the sequencer breaks
    assign clock_gate_en_o = seq_gate_off ? 8'h0 : (8'h1 << cur_src_q);
    assign current_source_o = cur_src_q;
    // primary submode only for primary sources
    assign primary_submode_o = primary_mode ? sub_cfg : oscsel_pkg::PRI_OFF;
    // pin function when not on the primary
    assign primary_output_pin_gpio_o = !primary_mode && pin_fn_cfg;
    assign divider_source_select_o = div_src_q;
    assign pll_enable_o = pll_mode || pll_on_q;
    assign pll_postscaler_select_o = post_q;
    assign fail_safe_monitor_en_o = monitor_en;
    assign pin_config_lock_o = pin_lock_q;
    assign primary_sleep_enable_o = pri_sleep_q;
    assign secondary_enable_o = sec_en_q;

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    AST_REQ_NEEDS_SWITCH: assert property ($rose(sw_req_q) |->
        switch_allowed) else $error("request set with switching off");
    AST_FAIL_NEEDS_MON: assert property ($rose(fail_q) |->
        $past(fail_s && monitor_en)) else $error("fail flag set wrongly");
    AST_LOCK_HOLDS_NEW: assert property ((loaded_q && lock_eff) |=>
        $stable(new_src_q)) else $error("new source changed under lock");
    AST_WRITE_LOCK: assert property ($changed(pin_lock_q) |->
        $past(unlocked_q)) else $error("control write without unlock");
    AST_ONE_WAY: assert property ((one_way_cfg && pin_lock_q) |=>
        pin_lock_q) else $error("one-way pin lock cleared");
    AST_COPY_ON_DONE: assert property (seq_done |=>
        (cur_src_q == $past(new_src_q)) && !sw_req_q)
        else $error("switch did not copy source");
    AST_PLL_ZERO: assert property ((seq_busy || !pll_mode) |=>
        !pll_lock_q) else $error("pll lock high out of pll mode");
    AST_RESERVED_DROP: assert property ((sw_req_q && !seq_busy &&
        new_src_q == oscsel_pkg::SRC_RESERVED) |=> !sw_req_q && !seq_busy)
        else $error("reserved request not dropped");
    AST_LOAD_CFG: assert property (load |=>
        cur_src_q == $past(start_cfg) && new_src_q == $past(start_cfg))
        else $error("source fields not loaded from config");
    AST_ACK_PULSE: assert property (ack_q |=> !ack_q)
        else $error("ack held two cycles");

    COV_SWITCH: cover property (seq_start ##[1:8] seq_done);
    COV_FAIL: cover property ($rose(fail_q));
    COV_UNLOCK_WRITE: cover property (osc_wr);
    COV_PLL_LOCK: cover property ($rose(pll_lock_q));

endmodule : oscsel_top

`default_nettype wire

// File: verif/tb_top.sv
// Purpose: self-checking bench for the oscillator select and switch control
// Assumes: one bus request at a time, ack sampled on the rising edge
// Notes: configuration pins change only while reset is held
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, nrst, cyc, stb, we, pll_lk, fail_det, pin_fn, one_way, ack;
    logic pin_gpio, pll_en, mon_en, pin_lock, pri_sleep, sec_en;
    logic [7:0] adr, gates;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, rd;
    logic [2:0] cur, div_src, src;
    logic [1:0] sub_o, smc, sub, post;
    int err_count = 0;
    int checks_done = 0;

    oscsel_top dut (
        .ref_clk_i(clk),
        .nrst_i(nrst),
        .wb_cyc_i(cyc),
        .wb_stb_i(stb),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(sel),
        .wb_dat_i(wdat),
        .wb_dat_o(rdat),
        .wb_ack_o(ack),
        .switch_monitor_cfg_i(smc),
        .primary_submode_cfg_i(sub),
        .startup_source_cfg_i(src),
        .osc_out_pin_function_cfg_i(pin_fn),
        .one_way_pin_lock_cfg_i(one_way),
        .pll_in_lock_i(pll_lk),
        .clock_fail_detect_i(fail_det),
        .clock_gate_en_o(gates),
        .current_source_o(cur),
        .primary_submode_o(sub_o),
        .primary_output_pin_gpio_o(pin_gpio),
        .divider_source_select_o(div_src),
        .pll_enable_o(pll_en),
        .pll_postscaler_select_o(post),
        .fail_safe_monitor_en_o(mon_en),
        .pin_config_lock_o(pin_lock),
        .primary_sleep_enable_o(pri_sleep),
        .secondary_enable_o(sec_en)
    );

    // free-running 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // one classic cycle; ack is seen before the edge's own updates land
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we} <= {2'b11, w};
        adr <= a;
        sel <= s;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        rd = rdat;
        {cyc, stb} <= 2'b00;
    endtask : bus

    task automatic rdr(input logic [7:0] a);
        bus(1'b0, a, 4'hf, 32'h0);
    endtask : rdr

    // control writes need both keys written just before
    task automatic ctl(input logic [31:0] d, input logic [3:0] s);
        bus(1'b1, 8'h08, 4'h1, {24'h0, oscsel_pkg::UNLOCK_KEY1});
        bus(1'b1, 8'h08, 4'h1, {24'h0, oscsel_pkg::UNLOCK_KEY2});
        bus(1'b1, 8'h00, s, d);
    endtask : ctl

    task automatic restart(input logic [1:0] m, input logic [2:0] c,
                           input logic ow);
        nrst <= 1'b0;
        smc <= m;
        src <= c;
        one_way <= ow;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
    endtask : restart

    // a hang costs far more than the ~550 cycles the tests take
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    initial begin
        // reset, monitor config, startup source and one-way pins are set by restart
        {cyc, stb, we, fail_det} <= 4'h0;
        {pll_lk, pin_fn} <= 2'h3;
        {adr, sel, wdat} <= 44'h0;
        sub <= 2'h1;
        restart(2'h3, 3'h7, 1'b1);
        rdr(8'h00);
        check(rd, 32'h7700);
        check({24'h0, gates}, 32'h80);
        check({29'h0, div_src}, 32'h0);
        check({31'h0, mon_en}, 32'h0);
        bus(1'b1, 8'h00, 4'h1, 32'h02);
        rdr(8'h00);
        check(rd, 32'h7700);
        ctl(32'h8810, 4'h3);
        rdr(8'h00);
        check(rd, 32'h7000);
        ctl(32'h0001, 4'h1);
        repeat (12) @(posedge clk);
        check({29'h0, cur}, 32'h7);
        check({30'h0, sub_o}, 32'h3);
        check({31'h0, pin_gpio}, 32'h1);
        ctl(32'h40, 4'h1);
        rdr(8'h00);
        check(rd & 32'h40, 32'h40);
        // clear attempt also sets the selection lock, monitor off
        ctl(32'h80, 4'h1);
        @(posedge clk);
        check({31'h0, pin_lock}, 32'h1);
        bus(1'b1, 8'h04, 4'h3, 32'h05a0);
        rdr(8'h04);
        check(rd, 32'h05a0);
        check({30'h0, post}, 32'h2);
        check({31'h0, pll_en}, 32'h1);
        rdr(8'h0c);
        check(rd, 32'h0);
        // pll never reports lock, so only the start-up timer can
        pll_lk <= 1'b0;
        restart(2'h0, 3'h1, 1'b0);
        check({30'h0, mon_en, pll_en}, 32'h3);
        rdr(8'h00);
        check(rd, 32'h1100);
        repeat (250) @(posedge clk);
        rdr(8'h00);
        check(rd, 32'h1120);
        ctl(32'h0201, 4'h3);
        repeat (12) @(posedge clk);
        rdr(8'h00);
        check(rd, 32'h2200);
        check({24'h0, gates}, 32'h04);
        check({30'h0, sub_o}, 32'h1);
        check({31'h0, pin_gpio}, 32'h0);
        ctl(32'h0601, 4'h3);
        repeat (12) @(posedge clk);
        check({29'h0, cur}, 32'h2);
        ctl(32'h0000, 4'h3);
        ctl(32'h0080, 4'h1);
        ctl(32'h0081, 4'h1);
        repeat (12) @(posedge clk);
        check({29'h0, cur}, 32'h2);
        bus(1'b1, 8'h04, 4'h1, 32'h00e0);
        rdr(8'h04);
        check(rd, 32'h0);
        check({29'h0, post, pll_en}, 32'h0);
        // drop the lock, then a separate request switches to the fast RC
        ctl(32'h0000, 4'h1);
        ctl(32'h0001, 4'h1);
        repeat (12) @(posedge clk);
        check({24'h0, gates}, 32'h01);
        fail_det <= 1'b1;
        repeat (6) @(posedge clk);
        rdr(8'h00);
        check(rd & 32'h8, 32'h8);
        fail_det <= 1'b0;
        ctl(32'h0e, 4'h1);
        rdr(8'h00);
        check(rd & 32'h8, 32'h8);
        check({30'h0, pri_sleep, sec_en}, 32'h3);
        ctl(32'h00, 4'h1);
        rdr(8'h00);
        check(rd & 32'h8, 32'h0);
        check({30'h0, pri_sleep, sec_en}, 32'h0);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
